// ### verilog/bwc_bus_wake_config.sv
// bwc_bus_wake_config: bus feature and wake/grant configuration bytes with wake request
// assumes mclk is the host bus clock and nrst the host bus reset; status pins are asynchronous
// assumes the configuration memory byte is offered once after reset on cfgLoadValid
// assumes the received byte stream arrives on mclk, already framed by the receiver
//
// Operation
// [R1] bit 5 of first byte enables message interrupts
// [R2] message interrupt enable loaded from configuration memory
// [R3] read-only bit 4 shows auxiliary power presence
// [R4] auxiliary power captured at reset, then held
// [R5] read-only slot width and clock frequency code
// [R6] read-only grant select delays frame one clock
// [R7] wake-pattern enable honoured only with power wake
// [R8] found wake pattern asserts wake request output
// [R9] pattern: six ones bytes, sixteen identity copies
`timescale 1ns/1ps
module bwc_bus_wake_config
   import bwc_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic [7:0]  regAddr,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [7:0]  regWdata,
   output logic      [7:0]  regRdata_q,
   input  wire logic        cfgLoadValid,
   input  wire logic [7:0]  cfgLoadByte,
   input  wire logic        auxPowerPin,
   input  wire logic        slotWidthPin,
   input  wire logic [2:0]  busClockFreqPin,
   input  wire logic        grantDelayPin,
   input  wire logic        powerWakeEnable,
   input  wire logic        wakeClear,
   input  wire logic        grantSeen,
   output logic             frameStart_q,
   input  wire logic        rxFrameStart,
   input  wire logic        rxByteValid,
   input  wire logic [7:0]  rxByte,
   input  wire logic        rxFrameGood,
   input  wire logic [47:0] nodeId,
   output logic             msiEnable_q,
   output logic             wakeRequest_n_q
);
   logic [5:0]  syncA_q;
   logic [5:0]  syncB_q;
   logic [1:0]  settle_q;
   logic        auxPresent_q;
   logic        grantFrameDelaySel_q;
   logic        slotWidthFlag_q;
   logic [2:0]  busClockFreqCode_q;
   logic        wakePatternEn_q;
   logic        grantPend_q;
   logic        patternFound;

   // register map as the host sees it; unlisted bits read as zero and ignore writes
   //   bus feature byte: b5 message interrupt enable, b4 auxiliary power present,
   //                     b3 slot width flag, b2:0 bus clock frequency code
   //   wake/grant byte:  b7 grant frame delay select, b5 wake-pattern enable
   // only the two enables are writable; the rest is a status or strap view

   // ==========================================================
   // address decode, shared by the write path and the read path
   function automatic logic addrHits(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction

   // ==========================================================
   // pin synchronisers: first stage feeds only the second stage
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         syncA_q <= 6'h00;
         syncB_q <= 6'h00;
      end else begin
         syncA_q <= {grantDelayPin, auxPowerPin, slotWidthPin, busClockFreqPin};
         syncB_q <= syncA_q;
      end
   end

   // ==========================================================
   // straps caught once after reset release, once the synchroniser has filled
   // the second stage still holds its reset value at the second edge, so the
   // capture waits for the third; pins must stay steady from release until then
   // later pin changes are ignored until the next host bus reset
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         settle_q             <= 2'h0;
         auxPresent_q         <= 1'b0;
         grantFrameDelaySel_q <= 1'b0;
      end else if (settle_q != BWC_STRAP_SETTLE) begin
         settle_q <= settle_q + 2'h1;
         if (settle_q + 2'h1 == BWC_STRAP_SETTLE) begin
            auxPresent_q         <= syncB_q[4];                              // R4
            grantFrameDelaySel_q <= syncB_q[5];                              // R6
         end
      end
   end

   // slot width and clock code follow the pins; they are static in practice
   // a pin change reaches a read only four edges later, through both sync stages
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         slotWidthFlag_q    <= 1'b0;
         busClockFreqCode_q <= 3'h0;
      end else begin
         slotWidthFlag_q    <= syncB_q[3];                                   // R5
         busClockFreqCode_q <= syncB_q[2:0];                                 // R5
      end
   end

   // ==========================================================
   // writable bits; a memory load in the same cycle as a write takes precedence
   // the load is expected only just after reset, so a host write lost to it there
   // is harmless, whereas the stored default must never be lost
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         msiEnable_q     <= 1'b0;
         wakePatternEn_q <= 1'b0;
      end else begin
         if (cfgLoadValid)
            msiEnable_q <= cfgLoadByte[BWC_BIT_MSI_EN];                      // R2
         else if (regWrite && addrHits(regAddr, BWC_OFS_BUS_FEATURE))
            msiEnable_q <= regWdata[BWC_BIT_MSI_EN];                         // R1
         if (regWrite && addrHits(regAddr, BWC_OFS_WAKE_GRANT))
            wakePatternEn_q <= regWdata[BWC_BIT_WAKE_PAT_EN];
      end
   end

   // ==========================================================
   // read port: reserved and unmapped bytes read as zero
   // a read in the cycle of a write shows the old value, as the data are sampled
   // before the write lands; the byte holds until the next read
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         regRdata_q <= BWC_BYTE_ZERO;
      end else if (regRead) begin
         regRdata_q <= BWC_BYTE_ZERO;
         if (addrHits(regAddr, BWC_OFS_BUS_FEATURE)) begin
            regRdata_q[BWC_BIT_MSI_EN]      <= msiEnable_q;                  // R1
            regRdata_q[BWC_BIT_AUX_PRESENT] <= auxPresent_q;                 // R3
            regRdata_q[BWC_BIT_SLOT_WIDTH]  <= slotWidthFlag_q;              // R5
            regRdata_q[BWC_BIT_CLK_CODE_HI:0] <= busClockFreqCode_q;         // R5
         end else if (addrHits(regAddr, BWC_OFS_WAKE_GRANT)) begin
            regRdata_q[BWC_BIT_GRANT_SEL]   <= grantFrameDelaySel_q;         // R6
            regRdata_q[BWC_BIT_WAKE_PAT_EN] <= wakePatternEn_q;
         end
      end
   end

   // ==========================================================
   // frame start after grant: next edge, or one extra clock when delay is selected
   // the select is the latched strap, so it cannot change under a pending grant
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         grantPend_q  <= 1'b0;
         frameStart_q <= 1'b0;
      end else begin
         grantPend_q  <= grantSeen && grantFrameDelaySel_q;                  // R6
         frameStart_q <= (grantSeen && !grantFrameDelaySel_q) || grantPend_q; // R6
      end
   end

   // ==========================================================
   // wake pattern detection
   // the matcher restarts at every frame start, so a run split over two frames
   // never counts; its flag is a single-cycle pulse after a good frame end
   bwc_wake_matcher #(
      .SYNC_BYTES (BWC_SYNC_BYTES),
      .ID_REPEATS (BWC_ID_REPEATS)
   ) uMatcher (
      .mclk           (mclk),
      .nrst           (nrst),
      .rxFrameStart   (rxFrameStart),
      .rxByteValid    (rxByteValid),
      .rxByte         (rxByte),
      .rxFrameGood    (rxFrameGood),
      .nodeId         (nodeId),
      .patternFound_q (patternFound)
   );

   // wake request is sticky low until cleared; a new match beats a clear
   // a clear that lands with a match is lost on purpose: dropping a wake event
   // would leave the host asleep, a spurious one only costs a wakeup
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         wakeRequest_n_q <= 1'b1;
      else if (patternFound && wakePatternEn_q && powerWakeEnable)           // R7
         wakeRequest_n_q <= 1'b0;                                            // R8
      else if (wakeClear)
         wakeRequest_n_q <= 1'b1;
   end
endmodule // bwc_bus_wake_config

// ### verilog/bwc_pkg.sv
// bwc_pkg: offsets, field positions and reset values of the bus and wake configuration bytes
// assumes byte-wide register access with 8-bit offsets
package bwc_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] BWC_OFS_BUS_FEATURE  = 8'h53;
   localparam logic [7:0] BWC_OFS_WAKE_GRANT   = 8'h54;
   // ==========================================================
   // field positions
   localparam int         BWC_BIT_MSI_EN       = 5;
   localparam int         BWC_BIT_AUX_PRESENT  = 4;
   localparam int         BWC_BIT_SLOT_WIDTH   = 3;
   localparam int         BWC_BIT_CLK_CODE_HI  = 2;
   localparam int         BWC_BIT_GRANT_SEL    = 7;
   localparam int         BWC_BIT_WAKE_PAT_EN  = 5;
   localparam int         BWC_CLK_CODE_W       = 3;
   // ==========================================================
   // reset values and constants
   localparam logic [7:0] BWC_BYTE_ZERO        = 8'h00;
   localparam logic [7:0] BWC_SYNC_BYTE        = 8'hFF;
   localparam int         BWC_ID_BYTES         = 6;
   localparam int         BWC_SYNC_BYTES       = 6;
   localparam int         BWC_ID_REPEATS       = 16;
   // straps are taken at the third edge after release: the second synchroniser
   // stage still shows its reset value at the second edge
   localparam logic [1:0] BWC_STRAP_SETTLE     = 2'h3;
endpackage

// ### verilog/bwc_wake_matcher.sv
// bwc_wake_matcher: finds a wake-pattern sequence in a received byte stream
// assumes bytes arrive on mclk with a start-of-frame pulse and a good-end pulse
`timescale 1ns/1ps
module bwc_wake_matcher
   import bwc_pkg::*;
#(
   parameter int SYNC_BYTES = BWC_SYNC_BYTES,
   parameter int ID_REPEATS = BWC_ID_REPEATS
) (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        rxFrameStart,
   input  wire logic        rxByteValid,
   input  wire logic [7:0]  rxByte,
   input  wire logic        rxFrameGood,
   input  wire logic [47:0] nodeId,
   output logic             patternFound_q
);
   typedef enum logic {BWC_HUNT, BWC_MATCH} bwc_state_e;

   bwc_state_e  state_q;
   logic [3:0]  ffCount_q;
   logic [2:0]  byteIdx_q;
   logic [4:0]  repCount_q;
   logic        seen_q;
   logic [7:0]  idByte;

   // node identity is sent most significant byte first
   assign idByte = nodeId[8*(BWC_ID_BYTES-1-int'(byteIdx_q)) +: 8];

   // ==========================================================
   // sequence tracker
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_q    <= BWC_HUNT;
         ffCount_q  <= 4'h0;
         byteIdx_q  <= 3'h0;
         repCount_q <= 5'h00;
         seen_q     <= 1'b0;
      end else if (rxFrameStart) begin
         state_q    <= BWC_HUNT;
         ffCount_q  <= 4'h0;
         byteIdx_q  <= 3'h0;
         repCount_q <= 5'h00;
         seen_q     <= 1'b0;
      end else if (rxByteValid) begin
         unique case (state_q)
            BWC_HUNT: begin
               // a run longer than six all-ones bytes still counts as sync
               if (rxByte == BWC_SYNC_BYTE) begin
                  if (int'(ffCount_q) < SYNC_BYTES) ffCount_q <= ffCount_q + 4'h1; // R9
               end else if (int'(ffCount_q) >= SYNC_BYTES && rxByte == idByte) begin
                  state_q   <= BWC_MATCH;                                    // R9
                  byteIdx_q <= 3'h1;
                  ffCount_q <= 4'h0;
               end else begin
                  ffCount_q <= 4'h0;
               end
            end
            BWC_MATCH: begin
               if (rxByte == idByte) begin
                  if (int'(byteIdx_q) == BWC_ID_BYTES-1) begin
                     byteIdx_q <= 3'h0;
                     if (int'(repCount_q) == ID_REPEATS-1) begin
                        seen_q  <= 1'b1;                                     // R9
                        state_q <= BWC_HUNT;
                     end
                     repCount_q <= repCount_q + 5'h01;
                  end else begin
                     byteIdx_q <= byteIdx_q + 3'h1;
                  end
               end else begin
                  // a break restarts the hunt; this byte may open a new sync run
                  state_q    <= BWC_HUNT;
                  byteIdx_q  <= 3'h0;
                  repCount_q <= 5'h00;
                  ffCount_q  <= (rxByte == BWC_SYNC_BYTE) ? 4'h1 : 4'h0;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // report only frames that end good, so a bad checksum never wakes the host
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) patternFound_q <= 1'b0;
      else       patternFound_q <= rxFrameGood && seen_q && !rxFrameStart;  // R9
   end
endmodule // bwc_wake_matcher

// ### bench/bwc_frame_src.sv
// bwc_frame_src: received-byte source that plays one wake-pattern frame per go pulse
// assumes the block takes a byte on the rising mclk edge while rxByteValid is high
`timescale 1ns/1ps
module bwc_frame_src (
   input  wire logic        mclk,
   input  wire logic        go,
   input  wire logic [4:0]  reps,
   input  wire logic [47:0] nodeId,
   output logic             rxFrameStart,
   output logic             rxByteValid,
   output logic [7:0]       rxByte,
   output logic             rxFrameGood
);
   // ==========================================================
   // frame player
   initial begin
      rxFrameStart = 1'h0;
      rxByteValid = 1'h0;
      rxByte = 8'h00;
      rxFrameGood = 1'h0;
   end
   // byte line is inverted between bytes so a stale value can never match by accident
   always @(posedge go) begin : playFrame
      int i;
      @(negedge mclk) rxFrameStart = 1'h1;
      @(negedge mclk) rxFrameStart = 1'h0;
      for (i = 0; i < 6 + 6 * reps; i++) begin
         rxByte = (i < 6) ? 8'hFF : nodeId[47 - 8 * ((i - 6) % 6) -: 8];
         rxByteValid = 1'h1;
         @(negedge mclk) rxByteValid = 1'h0;
         rxByte = ~rxByte;
         @(negedge mclk);
      end
      rxFrameGood = 1'h1;
      @(negedge mclk) rxFrameGood = 1'h0;
   end
endmodule // bwc_frame_src

// ### bench/bwc_bus_wake_config_chk.sv
// bwc_bus_wake_config_chk: port-level assertions for the configuration bytes
// assumes status pins stay steady for several cycles around each status read
`timescale 1ns/1ps
module bwc_bus_wake_config_chk
   import bwc_pkg::*;
(
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic [7:0]  regAddr,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [7:0]  regWdata,
   input wire logic [7:0]  regRdata_q,
   input wire logic        cfgLoadValid,
   input wire logic [7:0]  cfgLoadByte,
   input wire logic        slotWidthPin,
   input wire logic [2:0]  busClockFreqPin,
   input wire logic        powerWakeEnable,
   input wire logic        wakeClear,
   input wire logic        grantSeen,
   input wire logic        frameStart_q,
   input wire logic        rxFrameGood,
   input wire logic        msiEnable_q,
   input wire logic        wakeRequest_n_q
);
   // ==========================================================
   // assertions
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_msi_load: assert property (cfgLoadValid |=> msiEnable_q == $past(cfgLoadByte[5]))
      else $error("msi enable not loaded");
   a_msi_write: assert property (regWrite && regAddr == BWC_OFS_BUS_FEATURE && !cfgLoadValid
      |=> msiEnable_q == $past(regWdata[5])) else $error("msi enable not written");
   // two sync stages, the status flop and the read flop: pins are looked at four edges back
   a_status_read: assert property (regRead && regAddr == BWC_OFS_BUS_FEATURE
      |=> regRdata_q[3:0] == {$past(slotWidthPin, 4), $past(busClockFreqPin, 4)}
      && regRdata_q[5] == $past(msiEnable_q)) else $error("status read wrong");
   a_rdata_hold: assert property (!regRead |=> $stable(regRdata_q))
      else $error("read data moved without a read");
   a_grant_frame: assert property (grantSeen |-> ##[1:2] frameStart_q)
      else $error("no frame start after grant");
   a_frame_cause: assert property ($rose(frameStart_q) |-> $past(grantSeen)
      || $past(grantSeen, 2)) else $error("frame start without grant");
   a_wake_fall: assert property ($fell(wakeRequest_n_q) |-> $past(powerWakeEnable)
      && ($past(rxFrameGood, 2) || $past(rxFrameGood, 3))) else $error("stray wake request");
   a_wake_rise: assert property ($rose(wakeRequest_n_q) |-> $past(wakeClear))
      else $error("wake request released without clear");
endmodule // bwc_bus_wake_config_chk
bind bwc_bus_wake_config bwc_bus_wake_config_chk u_chk (.mclk(mclk), .nrst(nrst),
   .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
   .regRdata_q(regRdata_q), .cfgLoadValid(cfgLoadValid), .cfgLoadByte(cfgLoadByte),
   .slotWidthPin(slotWidthPin), .busClockFreqPin(busClockFreqPin), .wakeClear(wakeClear),
   .powerWakeEnable(powerWakeEnable), .grantSeen(grantSeen), .frameStart_q(frameStart_q),
   .rxFrameGood(rxFrameGood), .msiEnable_q(msiEnable_q), .wakeRequest_n_q(wakeRequest_n_q));

// ### bench/bwc_bus_wake_config_tb.sv
// bwc_bus_wake_config_tb: self-checking bench for the configuration bytes
// assumes bwc_frame_src and the checker bind are compiled before it
`timescale 1ns/1ps
module bwc_bus_wake_config_tb import bwc_pkg::*;;
   logic        mclk = 0, nrst = 0, regWrite = 0, regRead = 0, cfgLoadValid = 0, p, rdPend = 0;
   logic        auxPowerPin = 0, slotWidthPin = 0, grantDelayPin = 0, powerWakeEnable = 0;
   logic        wakeClear = 0, grantSeen = 0, go = 0, frameStart_q, msiEnable_q, wakeRequest_n_q;
   logic        rxFrameStart, rxByteValid, rxFrameGood;
   logic [2:0]  busClockFreqPin = 0;
   logic [4:0]  reps = 0;
   logic [7:0]  regAddr = 0, regWdata = 0, cfgLoadByte = 0, regRdata_q, rxByte, q[$];
   logic [47:0] nodeId = 0;
   logic [31:0] rng = 92;
   int          n_fail = 0, cmp_count = 0, cyc = 0;
   always #20 mclk = ~mclk;
   bwc_bus_wake_config i_dut (.mclk(mclk), .nrst(nrst), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata_q(regRdata_q),
      .cfgLoadValid(cfgLoadValid), .cfgLoadByte(cfgLoadByte), .auxPowerPin(auxPowerPin),
      .slotWidthPin(slotWidthPin), .busClockFreqPin(busClockFreqPin), .wakeClear(wakeClear),
      .grantDelayPin(grantDelayPin), .powerWakeEnable(powerWakeEnable), .grantSeen(grantSeen),
      .frameStart_q(frameStart_q), .rxFrameStart(rxFrameStart), .rxByteValid(rxByteValid),
      .rxByte(rxByte), .rxFrameGood(rxFrameGood), .nodeId(nodeId),
      .msiEnable_q(msiEnable_q), .wakeRequest_n_q(wakeRequest_n_q));
   bwc_frame_src i_src (.mclk(mclk), .go(go), .reps(reps), .nodeId(nodeId),
      .rxFrameStart(rxFrameStart), .rxByteValid(rxByteValid), .rxByte(rxByte),
      .rxFrameGood(rxFrameGood));
   // ==========================================================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      regAddr = a;
      regWdata = d;
      regWrite = 1;
      @(negedge mclk) regWrite = 0;
   endtask
   // reads only note what they expect; the watcher below does the compare
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk);
      regAddr = a;
      regRead = 1;
      q.push_back(e);
      @(negedge mclk) regRead = 0;
   endtask
   task grant(input logic [7:0] exp);
      logic [7:0] n;
      @(negedge mclk) grantSeen = 1;
      @(negedge mclk) grantSeen = 0;
      n = 1;
      while (frameStart_q !== 1'h1 && n < 4) begin
         @(negedge mclk);
         n++;
      end
      chk(n, exp);
   endtask
   task frame(input logic [4:0] r, input logic exp);
      int k;
      reps = r;
      go = 1;
      @(negedge mclk) go = 0;
      for (k = 0; k < 400 && rxFrameGood !== 1'h1; k++) @(posedge mclk);
      repeat (4) @(negedge mclk);
      chk(wakeRequest_n_q, exp);
   endtask
   always @(posedge mclk) rdPend <= regRead;
   always @(negedge mclk) if (rdPend) chk(regRdata_q, q.pop_front());
   // ceiling far above the roughly 700 cycles the sequence needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test;
      end
   end
   // ==========================================================
   // main sequence: two resets with opposite straps, then writes and wake frames
   initial begin
      for (int i = 0; i < 2; i++) begin
         p = i[0];
         nrst = 0;
         {auxPowerPin, slotWidthPin, grantDelayPin, busClockFreqPin} = {~p, ~p, ~p, 2'h0, p};
         repeat (12) @(negedge mclk) nrst = 0;
         nrst = 1;
         repeat (3) @(negedge mclk);
         auxPowerPin = p; // strap must not follow the pin
         cfgLoadValid = 1;
         cfgLoadByte = {2'h0, ~p, 5'h1F};
         @(negedge mclk) cfgLoadValid = 0;
         chk(msiEnable_q, {7'h00, ~p});
         rd(BWC_OFS_BUS_FEATURE, {2'h0, ~p, ~p, ~p, 2'h0, p});
         rd(BWC_OFS_WAKE_GRANT, {~p, 7'h00});
         grant(p ? 8'h01 : 8'h02);
      end
      rng = xs(rng);
      wr(BWC_OFS_BUS_FEATURE, rng[7:0]);
      chk(msiEnable_q, rng[5]);
      rd(BWC_OFS_BUS_FEATURE, {2'h0, rng[5], 5'h01});
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h00);
      wr(BWC_OFS_WAKE_GRANT, 8'hFF);
      rd(BWC_OFS_WAKE_GRANT, 8'h20);
      rng = xs(rng);
      nodeId[47:32] = rng[15:0];
      nodeId[31:0] = xs(rng);
      frame(5'h10, 1'h1);
      powerWakeEnable = 1;
      frame(5'h0F, 1'h1);
      frame(5'h10, 1'h0);
      wakeClear = 1;
      @(negedge mclk) wakeClear = 0;
      chk(wakeRequest_n_q, 1'h1);
      end_of_test;
   end
endmodule // bwc_bus_wake_config_tb
